// ---- dvr_rx_out.v ----
`timescale 1ns/10ps
`default_nettype none
`include "dvr_regs.vh"
module dvr_rx_out #(
  parameter [`DVR_CNT_W-1:0] LOSS_PIX = `DVR_LOSS_PIX,
  parameter [`DVR_CNT_W-1:0] ACQ_PIX = `DVR_ACQ_PIX
) (
  input wire clk_i,
  input wire rst_i,
  input wire link_clock_in_i,
  input wire [3*`DVR_CHAR_W-1:0] char_i,
  input wire [2:0] char_valid_i,
  input wire pixels_per_clock_select_i,
  input wire stagger_select_n_i,
  input wire output_clock_invert_i,
  input wire chip_power_down_n_i,
  input wire output_drive_down_n_i,
  output reg output_pixel_clock_o,
  output reg [`DVR_PIX_W-1:0] even_pixel_bus_o,
  output reg [`DVR_PIX_W-1:0] odd_pixel_bus_o,
  output reg display_enable_o,
  output reg hsync_o,
  output reg vsync_o,
  output reg [2:0] user_control_bits_o,
  output reg sync_detect_flag_o,
  output reg outputs_oe_n_o
);
  // Two-flop synchronisers for pins from outside the clock domain
  reg [1:0] lck_s_q, pix_s_q, stg_s_q, inv_s_q, pd_s_q, pdo_s_q;
  reg lck_d1_q;
  wire lck = lck_s_q[1];
  wire tick = lck & ~lck_d1_q;
  wire fall = ~lck & lck_d1_q;
  wire two_pix = pix_s_q[1];
  wire stagger_select_n = two_pix & ~stg_s_q[1];
  wire inv = inv_s_q[1];
  wire run = pd_s_q[1];

  wire [2:0] rdy;
  wire [2:0] isc;
  wire [3*`DVR_BYTE_W-1:0] pix;
  wire [5:0] ctl;
  wire emit = &rdy;

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : ch
      dvr_chan u_chan (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .char_i(char_i[g*`DVR_CHAR_W +: `DVR_CHAR_W]),
        .valid_i(char_valid_i[g] & run),
        .emit_i(emit),
        .ready_o(rdy[g]),
        .pixel_o(pix[g*`DVR_BYTE_W +: `DVR_BYTE_W]),
        .ctrl_o(ctl[g*2 +: 2]),
        .is_ctrl_o(isc[g])
      );
    end
  endgenerate

  // Latest aligned pixel in red, green, blue order
  reg [`DVR_PIX_W-1:0] lat_pix_q, first_q, pend_q;
  reg lat_de_q, lat_hs_q, lat_vs_q;
  reg [2:0] lat_ctl_q;
  reg de_edge_q;
  reg phase_q, ock_q, ock_d1_q;
  reg [`DVR_PER_W-1:0] per_cnt_q, per_q, stg_cnt_q;
  reg stg_busy_q;
  reg [`DVR_CNT_W-1:0] idle_q, acq_q;
  reg seen_q;

  wire launch = ock_q & ~ock_d1_q;
  wire latch_edge = ~ock_q & ock_d1_q;
  wire [`DVR_PER_W-1:0] quarter = per_q >> `DVR_QUARTER_SHIFT;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lck_s_q <= 2'b00;
      pix_s_q <= 2'b00;
      stg_s_q <= 2'b11;
      inv_s_q <= 2'b00;
      pd_s_q <= 2'b00;
      pdo_s_q <= 2'b00;
      lck_d1_q <= 1'b0;
    end else begin
      lck_s_q <= {lck_s_q[0], link_clock_in_i};
      pix_s_q <= {pix_s_q[0], pixels_per_clock_select_i};
      stg_s_q <= {stg_s_q[0], stagger_select_n_i};
      inv_s_q <= {inv_s_q[0], output_clock_invert_i};
      pd_s_q <= {pd_s_q[0], chip_power_down_n_i};
      pdo_s_q <= {pdo_s_q[0], output_drive_down_n_i};
      lck_d1_q <= lck;
    end
  end

  // Alignment result and display-enable decision
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lat_pix_q <= 24'h000000;
      lat_de_q <= 1'b0;
      lat_hs_q <= 1'b0;
      lat_vs_q <= 1'b0;
      lat_ctl_q <= 3'h0;
      de_edge_q <= 1'b0;
    end else begin
      de_edge_q <= 1'b0;
      if (emit) begin
        lat_de_q <= ~isc[0];
        de_edge_q <= (~isc[0]) ^ lat_de_q;
        if (!isc[0]) begin
          lat_pix_q <= {pix[2*`DVR_BYTE_W +: `DVR_BYTE_W], pix[`DVR_BYTE_W +: `DVR_BYTE_W],
                        pix[0 +: `DVR_BYTE_W]};
        end else begin
          lat_hs_q <= ctl[0];
          lat_vs_q <= ctl[1];
          lat_ctl_q <= {ctl[5:4], ctl[3]};
        end
      end
    end
  end

  // Output clock generation and pixel pairing
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_q <= 1'b0;
      ock_q <= 1'b0;
      ock_d1_q <= 1'b0;
      first_q <= 24'h000000;
      per_cnt_q <= 8'h00;
      per_q <= 8'h00;
    end else begin
      ock_d1_q <= ock_q;
      if (tick) begin
        per_q <= per_cnt_q;
        per_cnt_q <= 8'h01;
      end else if (per_cnt_q != `DVR_PER_MAX) begin
        per_cnt_q <= per_cnt_q + 8'h01;
      end
      if (!two_pix) begin
        ock_q <= lck;
        phase_q <= 1'b0;
      end else if (tick) begin
        phase_q <= ~phase_q;
        ock_q <= ~phase_q;
        // Pixel held at the raw-low tick opens the pair
        if (phase_q) begin
          first_q <= lat_pix_q;
        end
      end
    end
  end

  // Pixel, control and stagger outputs
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      even_pixel_bus_o <= 24'h000000;
      odd_pixel_bus_o <= 24'h000000;
      display_enable_o <= 1'b0;
      hsync_o <= 1'b0;
      vsync_o <= 1'b0;
      user_control_bits_o <= 3'h0;
      pend_q <= 24'h000000;
      stg_busy_q <= 1'b0;
      stg_cnt_q <= 8'h00;
    end else begin
      if (launch) begin
        display_enable_o <= lat_de_q;
        hsync_o <= lat_hs_q;
        vsync_o <= lat_vs_q;
        user_control_bits_o <= lat_ctl_q;
        if (two_pix) begin
          odd_pixel_bus_o <= lat_pix_q;
          if (stagger_select_n) begin
            pend_q <= first_q;
          end else begin
            even_pixel_bus_o <= first_q;
          end
        end else begin
          even_pixel_bus_o <= lat_pix_q;
          odd_pixel_bus_o <= 24'h000000;
        end
      end
      if (stagger_select_n && latch_edge) begin
        stg_busy_q <= 1'b1;
        stg_cnt_q <= (quarter == 8'h00) ? 8'h01 : quarter;
      end else if (stg_busy_q) begin
        if (stg_cnt_q <= 8'h01) begin
          stg_busy_q <= 1'b0;
          even_pixel_bus_o <= pend_q;
        end else begin
          stg_cnt_q <= stg_cnt_q - 8'h01;
        end
      end
    end
  end

  // Clock polarity and output drive
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      output_pixel_clock_o <= 1'b0;
      outputs_oe_n_o <= 1'b1;
    end else begin
      output_pixel_clock_o <= ock_q ^ inv;
      outputs_oe_n_o <= ~(run & pdo_s_q[1]);
    end
  end

  // Link activity from display-enable transition spacing
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      idle_q <= 20'h00000;
      acq_q <= 20'h00000;
      seen_q <= 1'b0;
      sync_detect_flag_o <= 1'b0;
    end else if (!run) begin
      idle_q <= 20'h00000;
      acq_q <= 20'h00000;
      seen_q <= 1'b0;
      sync_detect_flag_o <= 1'b0;
    end else begin
      if (de_edge_q) begin
        idle_q <= 20'h00000;
        seen_q <= 1'b1;
      end else if (tick && idle_q < LOSS_PIX) begin
        idle_q <= idle_q + 20'h00001;
      end
      if (sync_detect_flag_o) begin
        acq_q <= 20'h00000;
        if (idle_q >= LOSS_PIX && !de_edge_q) begin
          sync_detect_flag_o <= 1'b0;
          seen_q <= 1'b0;
        end
      end else if (idle_q >= LOSS_PIX && !de_edge_q) begin
        acq_q <= 20'h00000;
        seen_q <= 1'b0;
      end else if (seen_q && acq_q >= ACQ_PIX) begin
        sync_detect_flag_o <= 1'b1;
      end else if (tick && seen_q) begin
        acq_q <= acq_q + 20'h00001;
      end
    end
  end
endmodule
`default_nettype wire

// ---- dvr_regs.vh ----
// Behaviour
// - Output clock period is one pixel time, or two in two-pixel mode.
// - Sync-detect high means link active, judged from display-enable transition spacing.
// - Sync-detect drops after about one million pixel times without transitions.
// - Sync-detect rises about 1600 pixel times after transitions resume.
// - Staggered two-pixel mode updates even bus quarter pixel after latching edge.
// - Invert low: valid about falling edge; high: about rising edge.
// - Main power-down low puts data, control and clock outputs in high impedance.
// - Output-drive power-down low tristates outputs while receiver keeps running.
// - Three channels are aligned with up to one pixel time of skew.
// - Ten serial bits form one pixel period of the link clock.
// - Display-enable high with pixel data, low with sync and control bits.
`ifndef DVR_REGS_VH
`define DVR_REGS_VH
`define DVR_CHAR_W 10
`define DVR_BYTE_W 8
`define DVR_PIX_W 24
`define DVR_CTRL_00 10'h354
`define DVR_CTRL_01 10'h0ab
`define DVR_CTRL_10 10'h154
`define DVR_CTRL_11 10'h2ab
`define DVR_LOSS_PIX 1000000
`define DVR_ACQ_PIX 1600
`define DVR_CNT_W 20
`define DVR_PER_W 8
`define DVR_QUARTER_SHIFT 2
`define DVR_PER_MAX 8'hff
`endif

// ---- dvr_chan.v ----
`timescale 1ns/10ps
`default_nettype none
`include "dvr_regs.vh"
module dvr_chan (
  input wire clk_i,
  input wire rst_i,
  input wire [`DVR_CHAR_W-1:0] char_i,
  input wire valid_i,
  input wire emit_i,
  output wire ready_o,
  output reg [`DVR_BYTE_W-1:0] pixel_o,
  output reg [1:0] ctrl_o,
  output reg is_ctrl_o
);
  reg [`DVR_CHAR_W-1:0] hold_q;
  reg have_q;
  wire [`DVR_CHAR_W-1:0] cur;

  function [`DVR_BYTE_W-1:0] tmds_decode;
    input [`DVR_CHAR_W-1:0] c;
    reg [`DVR_BYTE_W-1:0] d;
    integer i;
    begin
      d = c[9] ? ~c[7:0] : c[7:0];
      tmds_decode[0] = d[0];
      for (i = 1; i < `DVR_BYTE_W; i = i + 1) begin
        tmds_decode[i] = c[8] ? (d[i] ^ d[i-1]) : ~(d[i] ^ d[i-1]);
      end
    end
  endfunction

  // Held character goes first; a fresh one then refills the slot
  assign ready_o = have_q | valid_i;
  assign cur = have_q ? hold_q : char_i;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hold_q <= 10'h000;
      have_q <= 1'b0;
    end else if (emit_i) begin
      if (have_q && valid_i) begin
        hold_q <= char_i;
      end
      have_q <= have_q & valid_i;
    end else if (valid_i) begin
      hold_q <= char_i;
      have_q <= 1'b1;
    end
  end

  always @* begin
    pixel_o = tmds_decode(cur);
    is_ctrl_o = 1'b1;
    ctrl_o = 2'b00;
    case (cur)
      `DVR_CTRL_00: ctrl_o = 2'b00;
      `DVR_CTRL_01: ctrl_o = 2'b01;
      `DVR_CTRL_10: ctrl_o = 2'b10;
      `DVR_CTRL_11: ctrl_o = 2'b11;
      default: is_ctrl_o = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// ---- dvr_chk_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
module dvr_chk #(
  parameter int LOSS_PIX = 40,
  parameter int PER = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pixels_per_clock_select_i,
  input wire logic stagger_select_n_i,
  input wire logic output_clock_invert_i,
  input wire logic chip_power_down_n_i,
  input wire logic output_drive_down_n_i,
  input wire logic output_pixel_clock_o,
  input wire logic [23:0] even_pixel_bus_o,
  input wire logic [23:0] odd_pixel_bus_o,
  input wire logic display_enable_o,
  input wire logic sync_detect_flag_o,
  input wire logic outputs_oe_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [31:0] quiet_q;
  // Cycles since display enable last moved
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) quiet_q <= '0;
    else quiet_q <= $changed(display_enable_o) ? '0 : quiet_q + 32'h1;
  end
  property p_pd_hiz;
    $fell(chip_power_down_n_i) |-> ##[1:4] outputs_oe_n_o;
  endproperty
  a_pd_hiz: assert property (p_pd_hiz) else $error("outputs not off after power down");
  property p_pdo_hiz;
    $fell(output_drive_down_n_i) |-> ##[1:4] outputs_oe_n_o;
  endproperty
  a_pdo_hiz: assert property (p_pdo_hiz) else $error("outputs not off after drive down");
  property p_pd_flag;
    (!chip_power_down_n_i) [*4] |-> !sync_detect_flag_o;
  endproperty
  a_pd_flag: assert property (p_pd_flag) else $error("sync flag high in power down");
  property p_half;
    $changed(output_pixel_clock_o) |=> $stable(output_pixel_clock_o) [*3];
  endproperty
  a_half: assert property (p_half) else $error("output clock half period short");
  property p_two;
    pixels_per_clock_select_i && $changed(output_pixel_clock_o)
      |=> $stable(output_pixel_clock_o) [*7];
  endproperty
  a_two: assert property (p_two) else $error("two pixel clock half period short");
  property p_latch;
    !pixels_per_clock_select_i && $changed(display_enable_o)
      |-> ##[0:1] (output_pixel_clock_o != output_clock_invert_i);
  endproperty
  a_latch: assert property (p_latch) else $error("data launched on latching edge");
  property p_stagger_select_n;
    pixels_per_clock_select_i && !stagger_select_n_i && $changed(even_pixel_bus_o)
      |-> $stable(odd_pixel_bus_o);
  endproperty
  a_stagger_select_n: assert property (p_stagger_select_n) else $error("even bus not staggered");
  property p_odd;
    (!pixels_per_clock_select_i) [*4] |-> odd_pixel_bus_o == 24'h0;
  endproperty
  a_odd: assert property (p_odd) else $error("odd bus used in one pixel mode");
  property p_loss;
    $fell(sync_detect_flag_o) && chip_power_down_n_i |-> quiet_q >= LOSS_PIX * PER - 32;
  endproperty
  a_loss: assert property (p_loss) else $error("sync flag fell too early");
  c_rise: cover property ($rose(sync_detect_flag_o));
  c_fall: cover property ($fell(sync_detect_flag_o));
  c_off: cover property ($rose(outputs_oe_n_o));
endmodule
bind dvr_rx_out dvr_chk #(.LOSS_PIX(LOSS_PIX)) u_dvr_chk (.clk_i, .rst_i,
  .pixels_per_clock_select_i, .stagger_select_n_i, .output_clock_invert_i,
  .chip_power_down_n_i, .output_drive_down_n_i, .output_pixel_clock_o, .even_pixel_bus_o,
  .odd_pixel_bus_o, .display_enable_o, .sync_detect_flag_o, .outputs_oe_n_o);
`default_nettype wire

// ---- dvr_tx.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "dvr_regs.vh"
module dvr_tx (
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic act_i,
  input wire logic skew_i,
  output logic lclk_o,
  output logic [29:0] char_o,
  output logic [2:0] valid_o
);
  logic [2:0] ph = 3'h0;
  logic [4:0] pix = 5'h0;
  logic [9:0] c;
  initial lclk_o = 1'b0;
  initial char_o = '0;
  initial valid_o = 3'h0;
  // Half blank with all control bits set, half active; pixel value alternates
  assign c = (act_i && pix[4]) ? (pix[0] ? 10'h1ff : 10'h0ff) : `DVR_CTRL_11;
  always @(posedge clk_i) begin
    lclk_o <= run_i && ph < 3'h4;
    // Red channel lags one cycle when skewed
    valid_o <= {run_i && (skew_i ? ph == 3'h1 : ph == 3'h0), {2{run_i && ph == 3'h0}}};
    if (run_i) begin
      ph <= ph + 3'h1;
      if (ph == 3'h0) begin
        char_o <= {3{c}};
        pix <= pix + 5'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- dvr_rx_out_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
module dvr_rx_out_bench;
  logic clk_i = 0, rst_i = 1, pps = 0, stg_n = 1, inv = 0, pd_n = 1, pdo_n = 1;
  logic run = 0, act = 0, skew = 0, lclk, opc, de, hs, vs, sdf, oe_n, de_hi = 0;
  logic [29:0] ch;
  logic [2:0] vld, ctl;
  logic [23:0] qe, qo;
  int err_total = 0, num_checks = 0, t;
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) if (de === 1'b1) de_hi = 1'b1;
  dvr_tx u_dvr_tx (.clk_i, .run_i(run), .act_i(act), .skew_i(skew), .lclk_o(lclk),
    .char_o(ch), .valid_o(vld));
  dvr_rx_out #(.LOSS_PIX(20'd40), .ACQ_PIX(20'd10)) u_dvr_rx_out (.clk_i, .rst_i,
    .link_clock_in_i(lclk), .char_i(ch), .char_valid_i(vld), .pixels_per_clock_select_i(pps),
    .stagger_select_n_i(stg_n), .output_clock_invert_i(inv), .chip_power_down_n_i(pd_n),
    .output_drive_down_n_i(pdo_n), .output_pixel_clock_o(opc), .even_pixel_bus_o(qe),
    .odd_pixel_bus_o(qo), .display_enable_o(de), .hsync_o(hs), .vsync_o(vs),
    .user_control_bits_o(ctl), .sync_detect_flag_o(sdf), .outputs_oe_n_o(oe_n));
  task automatic tick(int n); repeat (n) @(posedge clk_i); endtask
  task automatic cmp(string n, logic [23:0] e, logic [23:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wait_sdf(logic v);
    t = 0;
    while (sdf !== v && t < 700) begin tick(1); t++; end
    if (t >= 700) begin
      cmp("sdf_wait", v, sdf);
      final_report();
    end
  endtask
  task automatic wait_de();
    t = 0;
    while (de !== 1'b1 && t < 300) begin tick(1); t++; end
    if (t >= 300) begin
      cmp("de_wait", 1, de);
      final_report();
    end
    tick(40);
  endtask
  task automatic half(int e);
    int n;
    logic w;
    for (int k = 0; k < 2; k++) begin
      w = opc;
      n = 0;
      while (opc === w && n < 40) begin tick(1); n++; end
    end
    cmp("half_period", e, n);
  endtask
  task automatic do_reset(logic p, logic s, logic i, logic k);
    run <= 0;
    rst_i <= 1;
    pps <= p;
    stg_n <= s;
    inv <= i;
    skew <= k;
    tick(10);
    rst_i <= 0;
    tick(10);
    cmp("oe_n_after_reset", 0, oe_n);
  endtask
  task automatic t_acq();
    act <= 1;
    run <= 1;
    wait_sdf(1);
    cmp("sdf_rise_late", 1, t >= 190);
    cmp("de_seen", 1, de_hi);
    wait_de();
    cmp("even_pix", 1, qe == 24'h010101 || qe == 24'hffffff);
    cmp("odd_zero", 0, qo);
    half(4);
    $display("t_acq done");
  endtask
  task automatic t_loss();
    act <= 0;
    wait_sdf(0);
    cmp("sdf_fall_late", 1, t >= 180);
    cmp("blank_ctl", 24'h00001f, {hs, vs, ctl});
    act <= 1;
    wait_sdf(1);
    $display("t_loss done");
  endtask
  task automatic t_pdown(logic c);
    if (c) pd_n <= 0;
    else pdo_n <= 0;
    tick(6);
    cmp("oe_n_off", 1, oe_n);
    cmp("sdf_in_down", !c, sdf);
    pd_n <= 1;
    pdo_n <= 1;
    tick(6);
    cmp("oe_n_on", 0, oe_n);
    $display("t_pdown done");
  endtask
  task automatic t_two();
    do_reset(1, 0, 1, 1);
    act <= 1;
    run <= 1;
    wait_sdf(1);
    half(8);
    wait_de();
    cmp("pair_split", 24'hfefefe, qe ^ qo);
    $display("t_two done");
  endtask
  initial begin
    do_reset(0, 1, 0, 0);
    t_acq();
    t_loss();
    t_pdown(0);
    t_pdown(1);
    t_two();
    final_report();
  end
endmodule
`default_nettype wire
